//--- rtl/dma_hub_defines.vh
// Purpose: shared constants of the multichannel dma hub
// Assumes: one clock, asynchronous active-low reset
// Notes: included by dma_hub.v and dma_arbiter.v
//
// Overview of operation
// - 24 channels share a pool of 128 transfer descriptors.
// - two masters, processor and dma engine, start transactions independently.
// - eight spokes; both masters run together on different spokes.
// - transfers carry 8, 16, 24 or 32 bit data.
// - descriptors may be rewritten while the engine runs.
// - each channel has one of eight priority levels used by the arbiter.
// - start by routed trigger, processor request or another channel's end.
// - each channel raises up to two interrupt pulses per transfer.
// - a channel can be stalled or cancelled.
// - length 1 byte to 64 KB, or infinite.
// - processor wins over dma on the same spoke.
// - processor can never block dma forever.
// - lower level number preempts after the current bus transaction.
// - fairness gives levels 2..7 shares of 50, 25, 12.5 ... percent.
// - levels 0 and 1 bypass fairness and may take all bandwidth.
// - equal-level requesters are served round robin.
// - round robin disabled channel goes first within its level.
// - without fairness, grant strictly by level.
// - one descriptor moves data from source to sink.
// - a descriptor may name itself as successor.
// - on completion the named successor descriptor starts.
// - each descriptor carries its own source and destination.
`ifndef DMA_HUB_DEFINES_VH
`define DMA_HUB_DEFINES_VH
`define DMA_NCH 24
`define DMA_NTD 128
`define DMA_NLVL 8
`define DMA_FAIR_LVL 2
`define DMA_SPOKE_LSB 16
`define DMA_STARVE_NS 1600
`define DMA_CLK_NS 100
`define DMA_STARVE_CYC (`DMA_STARVE_NS / `DMA_CLK_NS)
`define DMA_F_INF 0
`define DMA_F_CHAIN 1
`define DMA_F_SINC 2
`define DMA_F_DINC 3
`define DMA_F_IRQ 4
`define DMA_FW 5
`endif

//--- rtl/dma_arbiter.v
// Purpose: channel arbiter with priority, fairness and round robin
// Assumes: take is high only in a cycle where gnt_valid is high
// Notes: grant outputs are combinational, registered by the hub
`timescale 1ns/1ps
`include "dma_hub_defines.vh"
module dma_arbiter #(
  parameter NCH = `DMA_NCH
) (
  input wire clk,
  input wire nrst,
  input wire [NCH-1:0] req,
  input wire [3*NCH-1:0] prio_flat,
  input wire [NCH-1:0] rr_dis,
  input wire fair_en,
  input wire take,
  output reg gnt_valid,
  output reg [4:0] gnt_idx
);
  reg [4:0] last_reg;
  reg [5:0] slot_reg;
  reg [7:0] lvl_has;
  reg [2:0] slot_lvl;
  reg [2:0] sel_lvl;
  reg found;
  reg rr_pick;
  integer i;
  integer j;
  always @*
  begin
    lvl_has = 8'h00;
    for (i = 0; i < NCH; i = i + 1)
      if (req[i])
        lvl_has[prio_flat[3*i +: 3]] = 1'b1;
    // trailing ones of the slot counter pick the level of this slot
    slot_lvl = 3'h7;
    found = 1'b0;
    for (i = 0; i < 5; i = i + 1)
      if (!found && !slot_reg[i])
      begin
        slot_lvl = i[2:0] + 3'h2;
        found = 1'b1;
      end
    sel_lvl = 3'h7;
    found = 1'b0;
    for (i = 0; i < 8; i = i + 1)
      if (!found && lvl_has[i])
      begin
        sel_lvl = i[2:0];
        found = 1'b1;
      end
    if (fair_en && !lvl_has[0] && !lvl_has[1] && lvl_has[slot_lvl])
      sel_lvl = slot_lvl;
    gnt_valid = 1'b0;
    gnt_idx = 5'h00;
    rr_pick = 1'b0;
    for (i = 0; i < NCH; i = i + 1)
      if (!gnt_valid && req[i] && rr_dis[i] &&
          prio_flat[3*i +: 3] == sel_lvl)
      begin
        gnt_valid = 1'b1;
        gnt_idx = i[4:0];
      end
    for (i = 1; i <= NCH; i = i + 1)
    begin
      j = last_reg + i;
      if (j >= NCH)
        j = j - NCH;
      if (!gnt_valid && req[j] && prio_flat[3*j +: 3] == sel_lvl)
      begin
        gnt_valid = 1'b1;
        gnt_idx = j[4:0];
        rr_pick = 1'b1;
      end
    end
  end
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      last_reg <= 5'h00;
      slot_reg <= 6'h00;
    end
    else if (take)
    begin
      slot_reg <= slot_reg + 6'h01;
      if (rr_pick)
        last_reg <= gnt_idx;
    end
  end
endmodule

//--- rtl/dma_hub.v
// Purpose: dma engine with descriptor chaining and hub bus sharing
// Assumes: spoke bus answers each phase with a one-cycle dma_ack
// Notes: spoke is taken from the three address bits starting at DMA_SPOKE_LSB
`timescale 1ns/1ps
`include "dma_hub_defines.vh"
module dma_hub #(
  parameter NCH = `DMA_NCH,
  parameter NTD = `DMA_NTD,
  parameter STARVE_CYC = `DMA_STARVE_CYC
) (
  input wire clk,
  input wire nrst,
  input wire td_wr,
  input wire [6:0] td_wr_idx,
  input wire [31:0] td_wr_src,
  input wire [31:0] td_wr_dst,
  input wire [15:0] td_wr_len,
  input wire [1:0] td_wr_size,
  input wire [6:0] td_wr_next,
  input wire [4:0] td_wr_flags,
  input wire ch_wr,
  input wire [4:0] ch_wr_idx,
  input wire ch_wr_enable,
  input wire [6:0] ch_wr_first,
  input wire [2:0] ch_wr_prio,
  input wire ch_wr_rr_dis,
  input wire ch_wr_chain_en,
  input wire [4:0] ch_wr_chain_ch,
  input wire fair_en,
  input wire [23:0] hw_trig,
  input wire cpu_trig,
  input wire [4:0] cpu_trig_idx,
  input wire [23:0] ch_stall,
  input wire cancel,
  input wire [4:0] cancel_idx,
  input wire cpu_req,
  input wire [2:0] cpu_spoke,
  output reg cpu_gnt,
  output reg dma_req,
  output reg dma_we,
  output reg [31:0] dma_addr,
  output reg [31:0] dma_wdata,
  output reg [1:0] dma_size,
  output reg [2:0] dma_spoke,
  input wire [31:0] dma_rdata,
  input wire dma_ack,
  output reg [23:0] irq_td,
  output reg [23:0] irq_ch,
  output reg [23:0] ch_busy,
  output reg act_valid,
  output reg [4:0] act_ch
);
  localparam S_IDLE = 2'h0;
  localparam S_RD = 2'h1;
  localparam S_WR = 2'h2;
  localparam S_UPD = 2'h3;
  //////////////////////////////////////////////////////////////////////
  // descriptor pool and channel configuration
  reg [31:0] td_src [0:NTD-1];
  reg [31:0] td_dst [0:NTD-1];
  reg [15:0] td_len [0:NTD-1];
  reg [1:0] td_sz [0:NTD-1];
  reg [6:0] td_nxt [0:NTD-1];
  reg [`DMA_FW-1:0] td_flg [0:NTD-1];
  reg [6:0] ch_first [0:NCH-1];
  reg [2:0] ch_prio [0:NCH-1];
  reg [4:0] ch_tgt [0:NCH-1];
  reg [NCH-1:0] ch_valid_reg;
  reg [NCH-1:0] ch_rrd_reg;
  reg [NCH-1:0] ch_cen_reg;
  // working copies per channel, reloaded from the pool per descriptor
  reg [6:0] wk_td [0:NCH-1];
  reg [31:0] wk_src [0:NCH-1];
  reg [31:0] wk_dst [0:NCH-1];
  reg [16:0] wk_rem [0:NCH-1];
  reg [NCH-1:0] loaded_reg;
  reg [NCH-1:0] pend_reg;
  reg [NCH-1:0] pend_next;
  reg [NCH-1:0] chain_trig_reg;
  reg [23:0] sync1_reg;
  reg [23:0] sync2_reg;
  reg [23:0] prev_reg;
  reg [1:0] state_reg;
  reg [4:0] cur_reg;
  reg cancel_cur_reg;
  reg [15:0] starve_reg;
  wire [23:0] hw_rise;
  wire [NCH-1:0] trig_vec;
  wire [NCH-1:0] arb_req;
  wire [NCH-1:0] cancel_vec;
  wire [3*NCH-1:0] prio_flat;
  wire gnt_valid;
  wire [4:0] gnt_idx;
  wire take;
  wire [6:0] cur_td;
  wire [`DMA_FW-1:0] cur_flg;
  wire [2:0] bytes;
  wire [2:0] step;
  wire [16:0] step17;
  wire cur_done;
  wire dma_want;
  wire [31:0] want_addr;
  wire [2:0] want_spoke;
  wire same;
  wire starve;
  wire dma_go;
  integer k;
  //////////////////////////////////////////////////////////////////////
  // configuration writes, allowed at any time
  always @(posedge clk)
  begin
    if (td_wr)
    begin
      td_src[td_wr_idx] <= td_wr_src;
      td_dst[td_wr_idx] <= td_wr_dst;
      td_len[td_wr_idx] <= td_wr_len;
      td_sz[td_wr_idx] <= td_wr_size;
      td_nxt[td_wr_idx] <= td_wr_next;
      td_flg[td_wr_idx] <= td_wr_flags;
    end
    if (ch_wr)
    begin
      ch_first[ch_wr_idx] <= ch_wr_first;
      ch_prio[ch_wr_idx] <= ch_wr_prio;
      ch_tgt[ch_wr_idx] <= ch_wr_chain_ch;
    end
  end
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ch_valid_reg <= {NCH{1'b0}};
      ch_rrd_reg <= {NCH{1'b0}};
      ch_cen_reg <= {NCH{1'b0}};
    end
    else if (ch_wr)
    begin
      ch_valid_reg[ch_wr_idx] <= ch_wr_enable;
      ch_rrd_reg[ch_wr_idx] <= ch_wr_rr_dis;
      ch_cen_reg[ch_wr_idx] <= ch_wr_chain_en;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // triggers: routed pins are synchronised, then edge detected
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_reg <= 24'h000000;
      sync2_reg <= 24'h000000;
      prev_reg <= 24'h000000;
    end
    else
    begin
      sync1_reg <= hw_trig;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end
  assign hw_rise = sync2_reg & ~prev_reg;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : gen_ch
      assign trig_vec[g] = ch_valid_reg[g] &
        (hw_rise[g] | (cpu_trig && cpu_trig_idx == g) |
        chain_trig_reg[g]);
      assign prio_flat[3*g +: 3] = ch_prio[g];
      assign cancel_vec[g] = cancel && cancel_idx == g;
    end
  endgenerate
  // a stalled channel keeps its place but is not offered for grant;
  // a channel being cancelled must not win the grant in that cycle
  assign arb_req = pend_reg & ch_valid_reg & ~ch_stall &
    ~cancel_vec;
  assign take = (state_reg == S_IDLE) && gnt_valid;
  dma_arbiter #(
    .NCH(NCH)
  ) u_arb (
    .clk(clk),
    .nrst(nrst),
    .req(arb_req),
    .prio_flat(prio_flat),
    .rr_dis(ch_rrd_reg),
    .fair_en(fair_en),
    .take(take),
    .gnt_valid(gnt_valid),
    .gnt_idx(gnt_idx)
  );
  //////////////////////////////////////////////////////////////////////
  // element size and remaining count of the active channel
  assign cur_td = wk_td[cur_reg];
  assign cur_flg = td_flg[cur_td];
  assign bytes = {1'b0, td_sz[cur_td]} + 3'h1;
  assign step = (!cur_flg[`DMA_F_INF] && wk_rem[cur_reg] < {14'h0000, bytes})
    ? wk_rem[cur_reg][2:0] : bytes;
  assign step17 = {14'h0000, step};
  assign cur_done = !cur_flg[`DMA_F_INF] &&
    wk_rem[cur_reg] == step17;
  //////////////////////////////////////////////////////////////////////
  // hub sharing between processor and dma on the spokes
  assign dma_want = (state_reg == S_RD) || (state_reg == S_WR);
  assign want_addr = (state_reg == S_WR) ? wk_dst[cur_reg] : wk_src[cur_reg];
  assign want_spoke = want_addr[`DMA_SPOKE_LSB +: 3];
  assign same = cpu_spoke == want_spoke;
  // starvation guard bounds how long the processor can hold a spoke
  assign starve = starve_reg >= STARVE_CYC[15:0];
  assign dma_go = dma_want && !dma_req && (!same ||
    (!cpu_gnt && (!cpu_req || starve)));
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cpu_gnt <= 1'b0;
      starve_reg <= 16'h0000;
    end
    else
    begin
      cpu_gnt <= cpu_req && !(same && dma_want &&
        (dma_req || dma_go || starve));
      if (dma_want && !dma_req && !dma_go)
      begin
        if (!starve)
          starve_reg <= starve_reg + 16'h0001;
      end
      else
        starve_reg <= 16'h0000;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // channel pending flags: a trigger in the clearing cycle wins
  always @*
  begin
    pend_next = pend_reg;
    if (state_reg == S_UPD && (cancel_cur_reg ||
        (cur_done && !cur_flg[`DMA_F_CHAIN])))
      pend_next[cur_reg] = 1'b0;
    // only a channel with a bus phase open defers its cancel
    if (cancel && !(dma_want && cur_reg == cancel_idx))
      pend_next[cancel_idx] = 1'b0;
    pend_next = pend_next | trig_vec;
  end
  //////////////////////////////////////////////////////////////////////
  // transfer sequencer: one read then one write per bus transaction
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= S_IDLE;
      cur_reg <= 5'h00;
      pend_reg <= {NCH{1'b0}};
      loaded_reg <= {NCH{1'b0}};
      chain_trig_reg <= {NCH{1'b0}};
      cancel_cur_reg <= 1'b0;
      dma_req <= 1'b0;
      dma_we <= 1'b0;
      dma_addr <= 32'h00000000;
      dma_wdata <= 32'h00000000;
      dma_size <= 2'h0;
      dma_spoke <= 3'h0;
      irq_td <= 24'h000000;
      irq_ch <= 24'h000000;
      ch_busy <= 24'h000000;
      act_valid <= 1'b0;
      act_ch <= 5'h00;
    end
    else
    begin
      pend_reg <= pend_next;
      ch_busy <= pend_next;
      irq_td <= 24'h000000;
      irq_ch <= 24'h000000;
      chain_trig_reg <= {NCH{1'b0}};
      for (k = 0; k < NCH; k = k + 1)
        if (trig_vec[k] && !pend_reg[k] && !loaded_reg[k])
          wk_td[k] <= ch_first[k];
      if (cancel && dma_want && cur_reg == cancel_idx)
        cancel_cur_reg <= 1'b1;
      else if (cancel)
        loaded_reg[cancel_idx] <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          act_valid <= gnt_valid;
          if (gnt_valid)
          begin
            // preemption happens here, between bus transactions
            cur_reg <= gnt_idx;
            act_ch <= gnt_idx;
            if (!loaded_reg[gnt_idx])
            begin
              wk_src[gnt_idx] <= td_src[wk_td[gnt_idx]];
              wk_dst[gnt_idx] <= td_dst[wk_td[gnt_idx]];
              wk_rem[gnt_idx] <= {1'b0, td_len[wk_td[gnt_idx]]} + 17'h1;
              loaded_reg[gnt_idx] <= 1'b1;
            end
            state_reg <= S_RD;
          end
        end
        S_RD, S_WR:
        begin
          if (dma_go)
          begin
            dma_req <= 1'b1;
            dma_we <= state_reg == S_WR;
            dma_addr <= want_addr;
            dma_spoke <= want_spoke;
            dma_size <= step[1:0] - 2'h1;
          end
          else if (dma_req && dma_ack)
          begin
            dma_req <= 1'b0;
            dma_we <= 1'b0;
            if (state_reg == S_RD)
            begin
              dma_wdata <= dma_rdata;
              state_reg <= S_WR;
            end
            else
              state_reg <= S_UPD;
          end
        end
        default:
        begin
          if (cur_flg[`DMA_F_SINC])
            wk_src[cur_reg] <= wk_src[cur_reg] + {29'h0, step};
          if (cur_flg[`DMA_F_DINC])
            wk_dst[cur_reg] <= wk_dst[cur_reg] + {29'h0, step};
          if (!cur_flg[`DMA_F_INF])
            wk_rem[cur_reg] <= wk_rem[cur_reg] - step17;
          if (cancel_cur_reg)
          begin
            loaded_reg[cur_reg] <= 1'b0;
            cancel_cur_reg <= 1'b0;
          end
          else if (cur_done)
          begin
            loaded_reg[cur_reg] <= 1'b0;
            irq_td[cur_reg] <= cur_flg[`DMA_F_IRQ];
            if (cur_flg[`DMA_F_CHAIN])
              wk_td[cur_reg] <= td_nxt[cur_td];
            else
            begin
              irq_ch[cur_reg] <= 1'b1;
              if (ch_cen_reg[cur_reg])
                chain_trig_reg[ch_tgt[cur_reg]] <= 1'b1;
            end
          end
          act_valid <= 1'b0;
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
  // pool size check is structural: 7-bit index spans all descriptors
  // is met by NCH channels and NTD shared entries
endmodule

//--- tb/dma_hub_chk.sv
// Purpose: port assertions of the dma hub
// Assumes: one clock, nrst resets asynchronously
// Notes: starvation bound is loose, element overheads vary
`timescale 1ns/1ps
module dma_hub_chk #(
  parameter STARVE_CYC = 16
) (
  input wire clk,
  input wire nrst,
  input wire cpu_req,
  input wire [2:0] cpu_spoke,
  input wire cpu_gnt,
  input wire dma_req,
  input wire dma_we,
  input wire [31:0] dma_addr,
  input wire [31:0] dma_wdata,
  input wire [1:0] dma_size,
  input wire [2:0] dma_spoke,
  input wire [31:0] dma_rdata,
  input wire dma_ack,
  input wire [23:0] irq_td,
  input wire [23:0] ch_busy,
  input wire act_valid,
  input wire [4:0] act_ch
);
  logic [31:0] rd_last;
  logic [7:0] blk;
  wire [31:0] wm = {{8{dma_size == 2'h3}}, {8{dma_size > 2'h1}},
    {8{dma_size != 2'h0}}, 8'hff};
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  // blk counts cycles the dma waits while the processor holds the hub
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_last <= 32'h0;
      blk <= 8'h0;
    end
    else
    begin
      if (dma_req && dma_ack && !dma_we)
        rd_last <= dma_rdata;
      if (dma_req || !act_valid || !cpu_gnt)
        blk <= 8'h0;
      else if (blk != 8'hff)
        blk <= blk + 8'h1;
    end
  end
  a_req_hold: assert property (dma_req && !dma_ack |=> dma_req &&
    $stable(dma_addr) && $stable(dma_we) && $stable(dma_wdata))
    else $error("dma fields moved before ack");
  a_req_drop: assert property (dma_req && dma_ack |=> !dma_req)
    else $error("dma request held after ack");
  a_rd_then_wr: assert property (dma_req && dma_ack && !dma_we
    |=> !dma_req ##[1:40] dma_req && dma_we)
    else $error("read not followed by write");
  a_wdata_copy: assert property (dma_req && dma_we |->
    ((dma_wdata ^ rd_last) & wm) == 32'h0)
    else $error("write data differs from read data");
  a_spoke_addr: assert property (dma_req |->
    dma_spoke == dma_addr[18:16])
    else $error("spoke does not match address");
  a_cpu_first: assert property (cpu_gnt && dma_req |->
    dma_spoke != cpu_spoke)
    else $error("both masters on one spoke");
  a_cpu_grant: assert property (cpu_req && !act_valid && !dma_req &&
    ch_busy == 24'h0 |=> cpu_gnt)
    else $error("processor not granted on idle hub");
  a_no_starve: assert property (blk <= STARVE_CYC + 8)
    else $error("dma starved by processor");
  a_irq_pulse: assert property (irq_td != 24'h0 |=>
    (irq_td & $past(irq_td)) == 24'h0)
    else $error("interrupt longer than one cycle");
  a_req_busy: assert property (dma_req |-> act_valid && ch_busy[act_ch])
    else $error("bus request without pending channel");
  a_reset_quiet: assert property ($rose(nrst) |-> !dma_req &&
    !cpu_gnt && !act_valid && ch_busy == 24'h0)
    else $error("outputs active after reset");
endmodule
bind dma_hub dma_hub_chk #(.STARVE_CYC(STARVE_CYC)) dma_hub_chk_i (.clk,
  .nrst, .cpu_req, .cpu_spoke, .cpu_gnt, .dma_req, .dma_we, .dma_addr,
  .dma_wdata, .dma_size, .dma_spoke, .dma_rdata, .dma_ack, .irq_td,
  .ch_busy, .act_valid, .act_ch);

//--- tb/spoke_mem.sv
// Purpose: byte memory answering the dma spoke bus
// Assumes: request and fields held until ack
// Notes: 0..3 wait cycles; idle read data toggles so stale data shows
`timescale 1ns/1ps
module spoke_mem (
  input wire clk,
  input wire dma_req,
  input wire dma_we,
  input wire [31:0] dma_addr,
  input wire [31:0] dma_wdata,
  input wire [1:0] dma_size,
  output logic [31:0] dma_rdata,
  output logic dma_ack
);
  logic [7:0] mem [logic [31:0]];
  int wt = 0;
  initial
  begin
    dma_ack = 1'h0;
    dma_rdata = 32'h0;
  end
  ////////////////////////////////////////
  always @(posedge clk)
  begin
    if (dma_ack || !dma_req)
    begin
      dma_ack <= 1'h0;
      dma_rdata <= ~dma_rdata;
      wt <= $urandom_range(3);
    end
    else if (wt != 0)
      wt <= wt - 1;
    else
    begin
      dma_ack <= 1'h1;
      for (int i = 0; i < 4; i++)
      begin
        if (dma_we && i <= dma_size)
          mem[dma_addr + i] = dma_wdata[8*i +: 8];
        dma_rdata[8*i +: 8] <= mem.exists(dma_addr + i) ?
          mem[dma_addr + i] : ~dma_addr[7:0];
      end
    end
  end
endmodule

//--- tb/tb_top.sv
// Purpose: self-checking bench of the dma hub
// Assumes: inputs change at the falling clock edge
// Notes: starvation count shortened to 4 cycles to keep runs short
`timescale 1ns/1ps
module tb_top;
  logic clk = '0, nrst = '0, td_wr = '0, ch_wr = '0, fair_en = '0;
  logic cpu_trig = '0, cancel = '0, cpu_req = '0, ch_wr_enable = '0;
  logic ch_wr_rr_dis = '0, ch_wr_chain_en = '0, got_act = '0;
  logic [6:0] td_wr_idx = '0, td_wr_next = '0, ch_wr_first = '0;
  logic [31:0] td_wr_src = '0, td_wr_dst = '0, s, d;
  logic [15:0] td_wr_len = '0;
  logic [1:0] td_wr_size = '0;
  logic [4:0] td_wr_flags = '0, ch_wr_idx = '0, ch_wr_chain_ch = '0;
  logic [4:0] cpu_trig_idx = '0, cancel_idx = '0, first_act = '0, ch;
  logic [2:0] ch_wr_prio = '0, cpu_spoke = '0;
  logic [23:0] hw_trig = '0, ch_stall = '0;
  wire cpu_gnt, dma_req, dma_we, dma_ack, act_valid;
  wire [31:0] dma_addr, dma_wdata, dma_rdata;
  wire [1:0] dma_size;
  wire [2:0] dma_spoke;
  wire [23:0] irq_td, irq_ch, ch_busy;
  wire [4:0] act_ch;
  int miscompares = 0, checked = 0, cyc = 0, ntd = 0, nch = 0, wc = 0;
  int n, ln;
  dma_hub #(.STARVE_CYC(4)) dma_hub_i (.clk, .nrst, .td_wr, .td_wr_idx,
    .td_wr_src, .td_wr_dst, .td_wr_len, .td_wr_size, .td_wr_next,
    .td_wr_flags, .ch_wr, .ch_wr_idx, .ch_wr_enable, .ch_wr_first,
    .ch_wr_prio, .ch_wr_rr_dis, .ch_wr_chain_en, .ch_wr_chain_ch, .fair_en,
    .hw_trig, .cpu_trig, .cpu_trig_idx, .ch_stall, .cancel, .cancel_idx,
    .cpu_req, .cpu_spoke, .cpu_gnt, .dma_req, .dma_we, .dma_addr,
    .dma_wdata, .dma_size, .dma_spoke, .dma_rdata, .dma_ack, .irq_td,
    .irq_ch, .ch_busy, .act_valid, .act_ch);
  spoke_mem spoke_mem_i (.clk, .dma_req, .dma_we, .dma_addr, .dma_wdata,
    .dma_size, .dma_rdata, .dma_ack);
  ////////////////////////////////////////
  task end_sim;
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] g, logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wtd(logic [6:0] i, logic [31:0] sa, logic [31:0] da,
    logic [15:0] l, logic [1:0] z, logic [6:0] nx, logic [4:0] f);
    {td_wr_idx, td_wr_src, td_wr_dst, td_wr_len} = {i, sa, da, l};
    {td_wr_size, td_wr_next, td_wr_flags, td_wr} = {z, nx, f, 1'h1};
    @(negedge clk);
    td_wr = 1'h0;
    @(negedge clk);
  endtask
  task automatic wch(logic [4:0] c, logic [6:0] fst, logic [2:0] p,
    logic ce, logic [4:0] cc);
    {ch_wr_idx, ch_wr_first, ch_wr_prio} = {c, fst, p};
    {ch_wr_chain_en, ch_wr_chain_ch, ch_wr_enable, ch_wr} = {ce, cc, 2'h3};
    @(negedge clk);
    ch_wr = 1'h0;
    @(negedge clk);
  endtask
  // hw path: the pin goes through a synchroniser, so wait before polling
  task automatic go(logic [4:0] c, logic hw);
    {wc, ntd, nch} = {27'h0, c, 64'h0};
    {cpu_trig_idx, cpu_trig} = {c, !hw};
    hw_trig[c] = hw;
    @(negedge clk);
    {hw_trig, cpu_trig} = 25'h0;
    repeat (3) @(negedge clk);
  endtask
  task automatic done(logic [23:0] m);
    for (int i = 0; i < 4000 && ((ch_busy & m) != 0 || act_valid); i++)
      @(negedge clk);
    if ((ch_busy & m) != 0 || act_valid)
      miscompares++;
    repeat (4) @(negedge clk);
  endtask
  task automatic fill(logic [31:0] a, int k, logic rnd);
    for (int i = 0; i < k; i++)
      spoke_mem_i.mem[a + i] = rnd ? 8'($urandom) : 8'h5a;
  endtask
  task automatic same(logic [31:0] sa, logic [31:0] da, int k);
    for (int i = 0; i < k; i++)
      chk("dst byte", spoke_mem_i.mem[da + i], spoke_mem_i.mem[sa + i]);
  endtask
  initial
  begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    ntd <= ntd + irq_td[wc];
    nch <= nch + irq_ch[wc];
    if (act_valid && !got_act)
      {got_act, first_act} <= {1'h1, act_ch};
    if (cyc > 20000)
    begin
      miscompares++;
      end_sim;
    end
  end
  ////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h0e1a));
    repeat (3) @(negedge clk);
    nrst = 1'h1;
    go(5'h3, 1'h0);
    chk("busy idle", ch_busy, 24'h0);
    for (int k = 0; k < 5; k++)
    begin
      ch = $urandom_range(23);
      ln = k == 0 ? 0 : $urandom_range(20);
      {s, d, fair_en} = {32'h100 * k, 32'h50000 + 32'h40 * k, k[0]};
      fill(s, ln + 1, 1'h1);
      fill(d, ln + 2, 1'h0);
      wtd(k, s, d, ln, k == 0 ? 3 : $urandom_range(3), k, 5'h1c);
      wch(ch, k, $urandom_range(7), 1'h0, 5'h0);
      go(ch, k[0]);
      done(24'hffffff);
      same(s, d, ln + 1);
      chk("guard", spoke_mem_i.mem[d + ln + 1], 8'h5a);
      chk("irq td", ntd, 1);
      chk("irq ch", nch, 1);
    end
    fill(32'h1000, 8, 1'h1);
    wtd(7'ha, 32'h1000, 32'h60000, 3, 1, 7'hb, 5'h1e);
    wtd(7'hb, 32'h1004, 32'h70000, 3, 2, 0, 5'h1c);
    wtd(7'hc, 32'h1000, 32'h60008, 1, 0, 0, 5'h0c);
    wch(5'h1, 7'ha, 3'h3, 1'h1, 5'h2);
    wch(5'h2, 7'hc, 3'h3, 1'h0, 5'h0);
    go(5'h1, 1'h0);
    wtd(7'hb, 32'h1004, 32'h60004, 3, 2, 0, 5'h1c);
    done(24'h6);
    done(24'h4);
    same(32'h1000, 32'h60000, 8);
    same(32'h1000, 32'h60008, 2);
    chk("irq td", ntd, 2);
    chk("irq ch", nch, 1);
    fill(32'h2000, 2, 1'h1);
    wtd(7'h14, 32'h2000, 32'h30000, 1, 0, 7'h14, 5'h1e);
    wch(5'h4, 7'h14, 3'h2, 1'h0, 5'h0);
    go(5'h4, 1'h0);
    for (int i = 0; i < 500 && ntd < 3; i++)
      @(negedge clk);
    chk("self repeat", ntd >= 3, 1);
    ch_stall[4] = 1'h1;
    repeat (30) @(negedge clk);
    n = ntd;
    repeat (30) @(negedge clk);
    chk("stall", ntd, n);
    {ch_stall, cancel_idx, cancel} = {24'h0, 5'h4, 1'h1};
    @(negedge clk);
    cancel = 1'h0;
    done(24'h10);
    chk("cancel", ch_busy[4], 1'h0);
    chk("cancel irq", ntd, n);
    fill(32'h3000, 4, 1'h1);
    wtd(7'h1e, 32'h3000, 32'h40000, 3, 0, 0, 5'h0c);
    wtd(7'h1f, 32'h3000, 32'h40010, 3, 0, 0, 5'h0c);
    wch(5'h7, 7'h1e, 3'h5, 1'h0, 5'h0);
    wch(5'h8, 7'h1f, 3'h1, 1'h0, 5'h0);
    {fair_en, got_act, hw_trig} = {2'h0, 24'h180};
    @(negedge clk);
    hw_trig = 24'h0;
    repeat (3) @(negedge clk);
    done(24'h180);
    chk("first grant", first_act, 5'h8);
    same(32'h3000, 32'h40000, 4);
    same(32'h3000, 32'h40010, 4);
    {cpu_spoke, cpu_req} = {3'h0, 1'h1};
    repeat (2) @(negedge clk);
    chk("cpu grant", cpu_gnt, 1'h1);
    fill(32'h500, 8, 1'h1);
    wtd(7'h28, 32'h500, 32'h50800, 7, 3, 0, 5'h0c);
    wch(5'h9, 7'h28, 3'h0, 1'h0, 5'h0);
    go(5'h9, 1'h0);
    done(24'h200);
    same(32'h500, 32'h50800, 8);
    cpu_req = 1'h0;
    fill(32'h3100, 2, 1'h1);
    wtd(7'h30, 32'h3100, 32'h41000, 1, 0, 0, 5'h0c);
    wtd(7'h31, 32'h3100, 32'h41010, 1, 0, 0, 5'h0c);
    wch(5'ha, 7'h30, 3'h4, 1'h0, 5'h0);
    ch_wr_rr_dis = 1'h1;
    wch(5'hb, 7'h31, 3'h4, 1'h0, 5'h0);
    {ch_wr_rr_dis, got_act, hw_trig} = {2'h0, 24'hc00};
    @(negedge clk);
    hw_trig = 24'h0;
    repeat (3) @(negedge clk);
    done(24'hc00);
    chk("rr head", first_act, 5'hb);
    same(32'h3100, 32'h41010, 2);
    same(32'h3100, 32'h41000, 2);
    end_sim;
  end
endmodule
